// >>> rtl/crcb_engine.sv
/*
 * CRC byte engine: input byte, checksum pair and polynomial select,
 * updated by software write strobes, with the checksum fold done in one cycle.
 * Assumes write strobes are single-cycle pulses from logic on CORE_CLK.
 */
`default_nettype none
`include "crcb_consts.svh"

// What this block does
// (RULE1) Each byte written to the input register folds into the stored 16-bit checksum.
// (RULE2) The fold of one byte completes in one cycle, ready for the next access.
// (RULE3) The fold starts by xoring the input byte into the checksum high byte.
// (RULE4) Each bit step shifts the working value left one place with a zero in.
// (RULE5) After the shift the value is xored with the polynomial only if the carry is set.
// (RULE6) The polynomial is 8005h for CRC-16 and 1021h for CRC-CCITT.
// (RULE7) The shift-and-reduce step runs eight times per byte.
// (RULE8) Each further byte repeats the full fold on the running value.
// (RULE9) Software clears both checksum bytes before a new calculation.
// (RULE10) Software picks the polynomial before feeding data.
// (RULE11) Software feeds 16-bit words low byte first, then high byte.
// (RULE12) Control bit 0 selects CCITT at 0 and CRC-16 at 1; other bits read zero.
// (RULE13) Input byte and both checksum bytes are read/write and reset to zero.
// (RULE14) The reduce decision uses the bit leaving position 15.
// (RULE15) A direct write to a checksum byte replaces that byte of the running value.
module crcb_engine (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire crcb_pkg::crcb_wr_t WR,
    output crcb_pkg::crcb_rd_t RD
);

    // ======================================================================
    // state
    // ======================================================================
    logic [7:0] byte_r;
    logic [7:0] byte_nxt;
    logic [15:0] sum_r;
    logic [15:0] sum_nxt;
    crcb_pkg::crcb_polynomial_select_t sel_r;
    crcb_pkg::crcb_polynomial_select_t sel_nxt;
    logic [15:0] folded;

    // the fold reads the current select, so a select write lands next byte
    crcb_step u_step (
        .sum_in(sum_r),
        .byte_in(WR.data),
        .polynomial_select_sel(sel_r),
        .sum_out(folded)
    );

    // ======================================================================
    // next-state: direct checksum writes win over a fold in the same cycle
    // ======================================================================
    always_comb begin
        byte_nxt = byte_r;
        sum_nxt = sum_r;
        sel_nxt = sel_r;
        if (WR.in_we) begin
            byte_nxt = WR.data;
            sum_nxt = folded; // [RULE1] [RULE2] [RULE8]
        end
        if (WR.lo_we) begin
            sum_nxt[7:0] = WR.data; // [RULE15]
        end
        if (WR.hi_we) begin
            sum_nxt[15:8] = WR.data; // [RULE15]
        end
        if (WR.ctl_we) begin
            sel_nxt = crcb_pkg::crcb_polynomial_select_t'(WR.data[`CRCB_SEL_BIT]); // [RULE12]
        end
    end

    // registers only; synchronous reset to the documented zeros
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            byte_r <= `CRCB_RST_BYTE; // [RULE13]
            sum_r <= `CRCB_RST_SUM; // [RULE13]
            sel_r <= crcb_pkg::crcb_polynomial_select_t'(`CRCB_RST_SEL);
        end else begin
            byte_r <= byte_nxt;
            sum_r <= sum_nxt;
            sel_r <= sel_nxt;
        end
    end

    // outputs straight from the flops; unused control bits read zero
    assign RD.byte_input = byte_r;
    assign RD.running_checksum = sum_r;
    assign RD.crc_control = {7'h00, sel_r}; // [RULE12]

    // ======================================================================
    // checks
    // ======================================================================
    // reference in the classic feedback form, independent of the step module
    function automatic logic [15:0] crcb_ref(
        input logic [15:0] s,
        input logic [7:0] d,
        input logic sel
    );
        logic [15:0] polynomial_select;
        logic fb;
        polynomial_select = sel ? `CRCB_POLYNOMIAL_SELECT_CRC16 : `CRCB_POLYNOMIAL_SELECT_CCITT;
        for (int i = 7; i >= 0; i--) begin
            fb = s[15] ^ d[i];
            s = {s[14:0], 1'b0} ^ (fb ? polynomial_select : 16'h0000);
        end
        return s;
    endfunction : crcb_ref

    logic pure_fold;
    assign pure_fold = WR.in_we && !WR.lo_we && !WR.hi_we;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SRST);

    byte_fold_a: assert property ( // [RULE1]
        pure_fold |=> sum_r == crcb_ref($past(sum_r), $past(WR.data), $past(sel_r)))
        else $error("checksum does not match folded byte");

    one_cycle_a: assert property ( // [RULE2]
        pure_fold ##1 pure_fold |=>
            sum_r == crcb_ref(crcb_ref($past(sum_r, 2), $past(WR.data, 2), $past(sel_r, 2)),
                $past(WR.data), $past(sel_r)))
        else $error("back to back bytes not folded each cycle");

    zero_fold_a: assert property ( // [RULE3]
        pure_fold && sum_r == 16'h0000 && WR.data == 8'h00 |=> sum_r == 16'h0000)
        else $error("zero byte on zero sum changed sum");

    ccitt_one_a: assert property ( // [RULE6]
        pure_fold && sum_r == 16'h0000 && WR.data == 8'h01 && sel_r == crcb_pkg::CRCB_CCITT
        |=> sum_r == 16'h1021)
        else $error("ccitt fold of 01 wrong");

    crc16_one_a: assert property ( // [RULE6]
        pure_fold && sum_r == 16'h0000 && WR.data == 8'h01 && sel_r == crcb_pkg::CRCB_CRC16
        |=> sum_r == 16'h8005)
        else $error("crc16 fold of 01 wrong");

    crc16_three_a: assert property ( // [RULE5]
        pure_fold && sum_r == 16'h0000 && WR.data == 8'h03 && sel_r == crcb_pkg::CRCB_CRC16
        |=> sum_r == 16'h000a)
        else $error("crc16 fold of 03 wrong");

    ccitt_seq_a: assert property ( // [RULE8]
        pure_fold && sum_r == 16'h0000 && WR.data == 8'h78 && sel_r == crcb_pkg::CRCB_CCITT
        ##1 pure_fold && WR.data == 8'h56 && sel_r == crcb_pkg::CRCB_CCITT
        |=> sum_r == 16'hbbc3)
        else $error("ccitt two-byte sequence wrong");

    sel_write_a: assert property ( // [RULE12]
        WR.ctl_we |=> RD.crc_control == {7'h00, $past(WR.data[0])})
        else $error("control write not reflected");

    // the default disable would mute this one, so it opts out explicitly
    reset_zero_a: assert property (@(posedge CORE_CLK) disable iff (1'b0) // [RULE13]
        SRST |=> RD == '0)
        else $error("registers not zero after reset");

    direct_low_a: assert property ( // [RULE15]
        WR.lo_we && !WR.hi_we |=> sum_r[7:0] == $past(WR.data) &&
            (sum_r[15:8] == ($past(WR.in_we) ? $past(folded[15:8]) : $past(sum_r[15:8]))))
        else $error("low checksum write not applied");

    byte_hold_a: assert property ( // [RULE13]
        !WR.in_we |=> byte_r == $past(byte_r))
        else $error("input byte changed without a write");

    // ======================================================================
    // hold, direct-write, end-of-table and two-byte sequence checks
    // ======================================================================
    // a stray update here would corrupt a calculation between software steps
    sum_hold_a: assert property ( // [RULE1]
        !WR.in_we && !WR.lo_we && !WR.hi_we |=> sum_r == $past(sum_r))
        else $error("checksum changed without a write");

    sel_hold_a: assert property ( // [RULE12]
        !WR.ctl_we |=> sel_r == $past(sel_r))
        else $error("select changed without a control write");

    input_load_a: assert property ( // [RULE13]
        WR.in_we |=> byte_r == $past(WR.data))
        else $error("input byte not stored");

    direct_high_a: assert property ( // [RULE15]
        WR.hi_we && !WR.lo_we |=> sum_r[15:8] == $past(WR.data) &&
            (sum_r[7:0] == ($past(WR.in_we) ? $past(folded[7:0]) : $past(sum_r[7:0]))))
        else $error("high checksum write not applied");

    // both halves at once is how software clears before a new run
    both_bytes_a: assert property ( // [RULE15]
        WR.hi_we && WR.lo_we |=> sum_r == {2{$past(WR.data)}})
        else $error("checksum pair write not applied");

    ccitt_seven_a: assert property ( // [RULE7]
        pure_fold && sum_r == 16'h0000 && WR.data == 8'h07 && sel_r == crcb_pkg::CRCB_CCITT
        |=> sum_r == 16'h70e7)
        else $error("ccitt fold of 07 wrong");

    // three set bits push carries out of position 15 in several steps
    crc16_seven_a: assert property ( // [RULE14]
        pure_fold && sum_r == 16'h0000 && WR.data == 8'h07 && sel_r == crcb_pkg::CRCB_CRC16
        |=> sum_r == 16'h8011)
        else $error("crc16 fold of 07 wrong");

    crc16_seq_a: assert property ( // [RULE8]
        pure_fold && sum_r == 16'h0000 && WR.data == 8'h78 && sel_r == crcb_pkg::CRCB_CRC16
        ##1 pure_fold && WR.data == 8'h56 && sel_r == crcb_pkg::CRCB_CRC16
        |=> sum_r == 16'h91f1)
        else $error("crc16 two-byte sequence wrong");

    ccitt_fold_c: cover property (pure_fold && sel_r == crcb_pkg::CRCB_CCITT);
    crc16_fold_c: cover property (pure_fold && sel_r == crcb_pkg::CRCB_CRC16);
    back_to_back_c: cover property (pure_fold ##1 pure_fold ##1 pure_fold);
    clear_then_fold_c: cover property (WR.lo_we && WR.hi_we && WR.data == 8'h00 ##[1:2] pure_fold);

endmodule : crcb_engine

`default_nettype wire

// >>> rtl/crcb_step.sv
/*
 * Combinational fold of one input byte into the running checksum.
 * Assumes the caller registers the result; no clock here.
 */
`default_nettype none
`include "crcb_consts.svh"

module crcb_step (
    input wire logic [15:0] sum_in,
    input wire logic [7:0] byte_in,
    input wire crcb_pkg::crcb_polynomial_select_t polynomial_select_sel,
    output logic [15:0] sum_out
);

    // one shift-and-reduce step on the working value
    function automatic logic [15:0] crcb_fold_bit(
        input logic [15:0] work,
        input logic [15:0] polynomial_select
    );
        logic carry;
        carry = work[15]; // bit leaving position 15 decides [RULE14]
        if (carry) begin
            return {work[14:0], 1'b0} ^ polynomial_select; // [RULE4] [RULE5]
        end
        return {work[14:0], 1'b0}; // [RULE4]
    endfunction : crcb_fold_bit

    // ======================================================================
    // byte update: xor into high byte, then eight reduce steps
    // ======================================================================
    always_comb begin
        logic [15:0] work;
        logic [15:0] polynomial_select;
        work = sum_in ^ {byte_in, 8'h00}; // [RULE3]
        polynomial_select = (polynomial_select_sel == crcb_pkg::CRCB_CRC16) ? `CRCB_POLYNOMIAL_SELECT_CRC16
                                                  : `CRCB_POLYNOMIAL_SELECT_CCITT; // [RULE6]
        for (int i = 0; i < `CRCB_BITS_PER_BYTE; i++) begin
            work = crcb_fold_bit(work, polynomial_select); // [RULE7]
        end
        sum_out = work;
    end

endmodule : crcb_step

`default_nettype wire

// >>> shared/crcb_consts.svh
/*
 * Constants for the CRC byte engine: polynomial values, field positions,
 * reset values and the update latency.
 * Assumes it is included by bare name from the rtl files.
 */
`ifndef CRCB_CONSTS_SVH
`define CRCB_CONSTS_SVH

// ==========================================================================
// reduction constants
// ==========================================================================
`define CRCB_POLYNOMIAL_SELECT_CCITT 16'h1021
`define CRCB_POLYNOMIAL_SELECT_CRC16 16'h8005

// ==========================================================================
// field layout
// ==========================================================================
`define CRCB_SEL_BIT 0
`define CRCB_BITS_PER_BYTE 8
`define CRCB_SUM_W 16

// ==========================================================================
// reset values
// ==========================================================================
`define CRCB_RST_BYTE 8'h00
`define CRCB_RST_SUM 16'h0000
`define CRCB_RST_SEL 1'b0

// ==========================================================================
// timing
// ==========================================================================
`define CRCB_UPDATE_CYCLES 1

`endif

// >>> shared/crcb_pkg.sv
/*
 * Types shared by the CRC byte engine and its step logic.
 * Assumes a single 100 MHz core clock and no other package.
 */
`default_nettype none

package crcb_pkg;

    // ======================================================================
    // polynomial choice as held in the control bit
    // ======================================================================
    typedef enum logic {
        CRCB_CCITT = 1'b0,
        CRCB_CRC16 = 1'b1
    } crcb_polynomial_select_t;

    // ======================================================================
    // one cycle of software writes; data is shared by all strobes
    // ======================================================================
    typedef struct packed {
        logic in_we;
        logic lo_we;
        logic hi_we;
        logic ctl_we;
        logic [7:0] data;
    } crcb_wr_t;

    // ======================================================================
    // what software reads back
    // ======================================================================
    typedef struct packed {
        logic [7:0] byte_input;
        logic [15:0] running_checksum;
        logic [7:0] crc_control;
    } crcb_rd_t;

endpackage : crcb_pkg

`default_nettype wire

// >>> tb/tb.sv
/*
 * Self-checking bench for the CRC byte engine: reset values, the single-byte
 * tables for both polynomials, a back-to-back byte stream, direct checksum
 * writes and the control bit.
 * Assumes the engine, its package and its header compile ahead of this file.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================================================
    // signals and expected tables
    // ======================================================================
    localparam int TIMEOUT_CYC = 2000; // whole run needs about 120 cycles
    logic core_clk;
    logic srst;
    crcb_pkg::crcb_wr_t wr;
    crcb_pkg::crcb_rd_t rd;
    int bad_count;
    int n_compared;
    int cyc;
    logic [15:0] one_ccitt [8] = '{16'h0000, 16'h1021, 16'h2042, 16'h3063,
                                   16'h4084, 16'h50a5, 16'h60c6, 16'h70e7};
    logic [15:0] one_crc16 [8] = '{16'h0000, 16'h8005, 16'h800f, 16'h000a,
                                   16'h801b, 16'h001e, 16'h0014, 16'h8011};
    logic [7:0] seq_in [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
    logic [15:0] seq_ccitt [4] = '{16'hff9f, 16'hbbc3, 16'ha367, 16'hd0fa};
    logic [15:0] seq_crc16 [4] = '{16'h0110, 16'h91f1, 16'hf2de, 16'h5c43};

    crcb_engine u_dut (.CORE_CLK(core_clk), .SRST(srst), .WR(wr), .RD(rd));

    // ======================================================================
    // clock, timeout and closing report
    // ======================================================================
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // a hang is cut short and counted as a mismatch
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == TIMEOUT_CYC) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    // ======================================================================
    // reference fold and compare tasks
    // ======================================================================
    // written apart from the engine so a shared slip cannot hide
    function automatic logic [15:0] fold(input logic [15:0] s, input logic [7:0] d,
                                         input logic sel);
        logic [15:0] t;
        logic [15:0] p;
        p = sel ? 16'h8005 : 16'h1021;
        t = s ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            t = t[15] ? ((t << 1) ^ p) : (t << 1);
        end
        return t;
    endfunction : fold

    task automatic chk_sum(input string what, input logic [15:0] exp);
        n_compared++;
        if (rd.running_checksum !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, rd.running_checksum);
        end
    endtask : chk_sum

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk_byte

    // one strobe set is launched just after an edge, taken at the next
    task automatic drive(input logic in, input logic lo, input logic hi, input logic ctl,
                         input logic [7:0] d);
        @(posedge core_clk);
        wr <= {in, lo, hi, ctl, d};
    endtask : drive

    // drop strobes and wait until the taken write has settled
    task automatic idle();
        @(posedge core_clk);
        wr <= '0;
        @(negedge core_clk);
    endtask : idle

    task automatic clear_sum();
        drive(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
        idle();
    endtask : clear_sum

    task automatic set_polynomial_select(input logic sel);
        drive(1'b0, 1'b0, 1'b0, 1'b1, {7'h00, sel});
        idle();
    endtask : set_polynomial_select

    // ======================================================================
    // scenarios
    // ======================================================================
    task automatic t_reset();
        @(negedge core_clk);
        chk_byte("input", 8'h00, rd.byte_input);
        chk_sum("sum", 16'h0000);
        chk_byte("control", 8'h00, rd.crc_control);
    endtask : t_reset

    task automatic t_single();
        for (int s = 0; s < 2; s++) begin
            set_polynomial_select(s[0]);
            for (int b = 0; b < 8; b++) begin
                clear_sum();
                drive(1'b1, 1'b0, 1'b0, 1'b0, b[7:0]);
                idle();
                chk_sum("one byte", s ? one_crc16[b] : one_ccitt[b]);
                chk_byte("input", b[7:0], rd.byte_input);
            end
        end
    endtask : t_single

    // words 5678h, 1234h fed low byte first, one byte every cycle
    task automatic t_stream();
        for (int s = 0; s < 2; s++) begin
            set_polynomial_select(s[0]);
            clear_sum();
            drive(1'b1, 1'b0, 1'b0, 1'b0, seq_in[0]);
            for (int i = 0; i < 4; i++) begin
                if (i < 3) begin
                    drive(1'b1, 1'b0, 1'b0, 1'b0, seq_in[i + 1]);
                    @(negedge core_clk);
                end else begin
                    idle();
                end
                chk_sum("stream", s ? seq_crc16[i] : seq_ccitt[i]);
            end
        end
    endtask : t_stream

    task automatic t_direct();
        logic [15:0] e;
        set_polynomial_select(1'b1);
        drive(1'b0, 1'b0, 1'b1, 1'b0, 8'ha5);
        drive(1'b0, 1'b1, 1'b0, 1'b0, 8'h3c);
        idle();
        chk_sum("direct", 16'ha53c);
        drive(1'b1, 1'b0, 1'b0, 1'b0, 8'h9e);
        idle();
        e = fold(16'ha53c, 8'h9e, 1'b1);
        chk_sum("seeded fold", e);
        // low byte write in the fold cycle wins that byte only
        drive(1'b1, 1'b1, 1'b0, 1'b0, 8'h77);
        idle();
        e = fold(e, 8'h77, 1'b1);
        chk_sum("override", {e[15:8], 8'h77});
    endtask : t_direct

    task automatic t_control();
        set_polynomial_select(1'b1);
        drive(1'b0, 1'b0, 1'b0, 1'b1, 8'hfe);
        idle();
        chk_byte("control", 8'h00, rd.crc_control);
        drive(1'b0, 1'b0, 1'b0, 1'b1, 8'hff);
        idle();
        chk_byte("control", 8'h01, rd.crc_control);
        set_polynomial_select(1'b0);
        clear_sum();
        // select changes with the byte: the fold still uses the old one
        drive(1'b1, 1'b0, 1'b0, 1'b1, 8'h01);
        idle();
        chk_sum("old select", 16'h1021);
        clear_sum();
        drive(1'b1, 1'b0, 1'b0, 1'b0, 8'h01);
        idle();
        chk_sum("new select", 16'h8005);
    endtask : t_control

    task automatic t_midreset();
        @(posedge core_clk);
        srst <= 1'b1;
        @(posedge core_clk);
        srst <= 1'b0;
        t_reset();
    endtask : t_midreset

    // ======================================================================
    // main sequence
    // ======================================================================
    initial begin
        srst = 1'b1;
        wr = '0;
        bad_count = 0;
        n_compared = 0;
        cyc = 0;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        t_reset();
        t_single();
        t_stream();
        t_direct();
        t_control();
        t_midreset();
        test_done();
    end

endmodule : tb

`default_nettype wire
